// ==== logic/pwc_consts.vh ====
/*
  Constants for the periodic wake-up counter: register indices, field
  positions, reset values, source and divider encodings.
  Assumes inclusion by bare name from the design files.
*/
`ifndef PWC_CONSTS_VH
`define PWC_CONSTS_VH

`define PWC_ADDR_W        2
`define PWC_IDX_SC        2'h0
`define PWC_IDX_CNT       2'h1
`define PWC_IDX_LIM       2'h2

`define PWC_BIT_FLAG      7
`define PWC_SRC_HI        6
`define PWC_SRC_LO        5
`define PWC_BIT_IRQE      4
`define PWC_DIV_HI        3
`define PWC_DIV_LO        0

`define PWC_SC_RESET      8'h00
`define PWC_LIM_RESET     8'h00
`define PWC_CNT_RESET     8'h00
`define PWC_ZERO8         8'h00
`define PWC_RD_UNMAPPED   8'h00

`define PWC_SRC_LPO       2'h0
`define PWC_SRC_EXT       2'h1

`define PWC_DIV_OFF       4'h0
`define PWC_PS_W          18
`define PWC_PS_ZERO       18'h00000
`define PWC_PS_ONE        18'h00001

`endif

// ==== logic/pwc_prescaler.v ====
/*
  Prescaler for the periodic wake-up counter. Divides source ticks by the
  ratio that divider_select and source_select bit 0 choose.
  Assumes src_tick is a one-cycle pulse in the mclk domain.
*/
`timescale 1ns/10ps
`include "pwc_consts.vh"

module pwc_prescaler (
  // Clock and reset.
  input  wire       mclk,
  input  wire       reset_n,
  // Control.
  input  wire       src_tick,
  input  wire       freeze,
  input  wire       clear,
  input  wire       range_sel,
  input  wire [3:0] divider_select,
  // Prescaler output pulse.
  output reg        ps_tick
);

  reg  [`PWC_PS_W-1:0] ps_cnt_reg;
  wire [`PWC_PS_W-1:0] ratio;

  // Returns the divide ratio; zero means the prescaler is off.
  function [`PWC_PS_W-1:0] div_ratio;
    input       hi;
    input [3:0] code;
    begin
      case ({hi, code})
        5'h01: div_ratio = 18'd8;
        5'h02: div_ratio = 18'd32;
        5'h03: div_ratio = 18'd64;
        5'h04: div_ratio = 18'd128;
        5'h05: div_ratio = 18'd256;
        5'h06: div_ratio = 18'd512;
        5'h07: div_ratio = 18'd1024;
        5'h08: div_ratio = 18'd1;
        5'h09: div_ratio = 18'd2;
        5'h0a: div_ratio = 18'd4;
        5'h0b: div_ratio = 18'd10;
        5'h0c: div_ratio = 18'd16;
        5'h0d: div_ratio = 18'd100;
        5'h0e: div_ratio = 18'd500;
        5'h0f: div_ratio = 18'd1000;
        5'h11: div_ratio = 18'd1024;
        5'h12: div_ratio = 18'd2048;
        5'h13: div_ratio = 18'd4096;
        5'h14: div_ratio = 18'd8192;
        5'h15: div_ratio = 18'd16384;
        5'h16: div_ratio = 18'd32768;
        5'h17: div_ratio = 18'd65536;
        5'h18: div_ratio = 18'd1000;
        5'h19: div_ratio = 18'd2000;
        5'h1a: div_ratio = 18'd5000;
        5'h1b: div_ratio = 18'd10000;
        5'h1c: div_ratio = 18'd20000;
        5'h1d: div_ratio = 18'd50000;
        5'h1e: div_ratio = 18'd100000;
        5'h1f: div_ratio = 18'd200000;
        default: div_ratio = `PWC_PS_ZERO;
      endcase
    end
  endfunction

  assign ratio = div_ratio(range_sel, divider_select);

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ps_cnt_reg <= `PWC_PS_ZERO;
      ps_tick    <= 1'b0;
    end else if (clear) begin
      ps_cnt_reg <= `PWC_PS_ZERO;
      ps_tick    <= 1'b0;
    end else begin
      ps_tick <= 1'b0;
      if (src_tick && !freeze && ratio != `PWC_PS_ZERO) begin
        if (ps_cnt_reg + `PWC_PS_ONE >= ratio) begin
          ps_cnt_reg <= `PWC_PS_ZERO;
          ps_tick    <= 1'b1;
        end else begin
          ps_cnt_reg <= ps_cnt_reg + `PWC_PS_ONE;
        end
      end
    end
  end

endmodule // pwc_prescaler

// ==== logic/pwc_src_sync.v ====
/*
  Source selection and edge detection for the periodic wake-up counter.
  Picks one of three counting clocks, brings it into the mclk domain with a
  two-stage synchroniser and emits a one-cycle pulse per rising edge.
  Assumes every source clock runs well below half the mclk rate.
*/
`timescale 1ns/10ps
`include "pwc_consts.vh"

module pwc_src_sync (
  // Clock and reset.
  input  wire       mclk,
  input  wire       reset_n,
  // Source clocks and selection.
  input  wire       low_power_osc_clock,
  input  wire       external_ref_clock,
  input  wire       internal_ref_clock,
  input  wire [1:0] source_select,
  // Rising-edge pulse of the selected source.
  output reg        src_tick
);

  reg  src_mux;
  reg  sync1_reg;
  reg  sync2_reg;
  reg  sync3_reg;

  always @* begin
    case (source_select)
      `PWC_SRC_LPO: src_mux = low_power_osc_clock;
      `PWC_SRC_EXT: src_mux = external_ref_clock;
      default:      src_mux = internal_ref_clock;
    endcase
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
      src_tick  <= 1'b0;
    end else begin
      sync1_reg <= src_mux;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      src_tick  <= sync2_reg & ~sync3_reg;
    end
  end

endmodule // pwc_src_sync

// ==== logic/pwc_top.v ====
/*
  Periodic wake-up counter: status/control, count and match limit registers,
  prescaled 8-bit up-counter with match flag and interrupt request.
  Assumes a simple synchronous register port on mclk and source clocks that
  are slow against mclk. The block has no off-chip pins.
  Assumes the chip raises deep_stop_mode only while the external and internal
  reference clocks are switched off, and debug_active only in background debug.
  Assumes software never raises both register strobes in one cycle.
*/
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`include "pwc_consts.vh"

module pwc_top (
  // Clock and reset.
  input  wire                  mclk,
  input  wire                  reset_n,
  // Counting clock sources.
  input  wire                  low_power_osc_clock,
  input  wire                  external_ref_clock,
  input  wire                  internal_ref_clock,
  // Chip mode inputs.
  input  wire                  deep_stop_mode,
  input  wire                  light_stop_mode,
  input  wire                  debug_active,
  // Register port.
  input  wire [`PWC_ADDR_W-1:0] reg_addr,
  input  wire [7:0]            reg_wdata,
  input  wire                  reg_write,
  input  wire                  reg_read,
  output reg  [7:0]            reg_rdata,
  // Interrupt request to the processor.
  output reg                   match_irq
);

  reg        match_flag_reg;
  reg  [1:0] source_select_reg;
  reg        match_irq_enable_reg;
  reg  [3:0] divider_select_reg;
  reg  [7:0] match_limit_reg;
  reg  [7:0] count_reg;
  reg  [7:0] rdata_next;
  reg        flag_next;
  reg  [7:0] count_next;
  reg        irq_next;

  wire       src_tick;
  wire       src_gated;
  wire       ps_tick;
  wire       wr_sc;
  wire       wr_lim;
  wire       sel_change;
  wire       cnt_clear;
  wire       match_wrap;
  wire [7:0] status_word;

  // Decodes a write strobe for one register index.
  function wr_hit;
    input                   strobe;
    input [`PWC_ADDR_W-1:0] addr;
    input [`PWC_ADDR_W-1:0] idx;
    begin
      wr_hit = strobe & (addr == idx);
    end
  endfunction

  assign wr_sc  = wr_hit(reg_write, reg_addr, `PWC_IDX_SC);
  assign wr_lim = wr_hit(reg_write, reg_addr, `PWC_IDX_LIM);

  // Returns high when a written field differs from the value held now.
  // Rewriting a field with its own value must not restart counting.
  function field_changed;
    input [3:0] written;
    input [3:0] held;
    begin
      field_changed = (written != held);
    end
  endfunction

  assign sel_change = wr_sc &
    (field_changed({2'b00, reg_wdata[`PWC_SRC_HI:`PWC_SRC_LO]},
                   {2'b00, source_select_reg}) |
     field_changed(reg_wdata[`PWC_DIV_HI:`PWC_DIV_LO], divider_select_reg));

  assign cnt_clear = sel_change | wr_lim;

  // Returns high when the selected source may count in the current power mode.
  // In deep stop only the low-power oscillator keeps running; the other two
  // sources are switched off by the chip, so their edges are not trusted.
  function src_alive;
    input       deep;
    input [1:0] src;
    begin
      src_alive = ~deep | (src == `PWC_SRC_LPO);
    end
  endfunction

  assign src_gated = src_tick & src_alive(deep_stop_mode, source_select_reg);

  pwc_src_sync u_src_sync (
    .mclk                (mclk),
    .reset_n             (reset_n),
    .low_power_osc_clock (low_power_osc_clock),
    .external_ref_clock  (external_ref_clock),
    .internal_ref_clock  (internal_ref_clock),
    .source_select       (source_select_reg),
    .src_tick            (src_tick)
  );

  pwc_prescaler u_prescaler (
    .mclk           (mclk),
    .reset_n        (reset_n),
    .src_tick       (src_gated),
    .freeze         (debug_active),
    .clear          (cnt_clear),
    .range_sel      (source_select_reg[0]),
    .divider_select (divider_select_reg),
    .ps_tick        (ps_tick)
  );

  assign match_wrap = ps_tick & ~cnt_clear & (count_reg == match_limit_reg);

  // Reset state.
  // Control fields take effect on the edge of the write; the clear that a
  // changed field causes lands on that same edge, so no tick of the old
  // setting can slip in between.
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      source_select_reg    <= `PWC_SRC_LPO;
      match_irq_enable_reg <= 1'b0;
      divider_select_reg   <= `PWC_DIV_OFF;
    end else if (wr_sc) begin
      source_select_reg    <= reg_wdata[`PWC_SRC_HI:`PWC_SRC_LO];
      match_irq_enable_reg <= reg_wdata[`PWC_BIT_IRQE];
      divider_select_reg   <= reg_wdata[`PWC_DIV_HI:`PWC_DIV_LO];
    end
  end

  // Match limit; any write also restarts prescaler and count.
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      match_limit_reg <= `PWC_LIM_RESET;
    end else if (wr_lim) begin
      match_limit_reg <= reg_wdata;
    end
  end

  // Main count; frozen in debug because the prescaler then emits no ticks.
  // A clearing write wins over a wrap in the same cycle, so the count always
  // restarts from zero after software changes the selection or writes the limit.
  always @* begin
    count_next = count_reg;
    if (cnt_clear) begin
      count_next = `PWC_ZERO8;
    end else if (match_wrap) begin
      count_next = `PWC_ZERO8;
    end else if (ps_tick) begin
      count_next = count_reg + 8'h01;
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= `PWC_CNT_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

  always @* begin
    flag_next = match_flag_reg;
    if (wr_sc && reg_wdata[`PWC_BIT_FLAG]) begin
      flag_next = 1'b0;
    end
    if (match_wrap) begin
      flag_next = 1'b1;
    end
  end

  // Interrupt gating.
  // The enable bit written together with a flag clear acts on the same edge,
  // so software never sees a stale request after disabling it, and the
  // request follows the flag that software reads back while the enable bit is set.
  always @* begin
    irq_next = flag_next & match_irq_enable_reg;
    if (wr_sc) begin
      irq_next = flag_next & reg_wdata[`PWC_BIT_IRQE];
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      match_flag_reg <= 1'b0;
      match_irq      <= 1'b0;
    end else begin
      match_flag_reg <= flag_next;
      match_irq      <= irq_next;
    end
  end

  assign status_word = {match_flag_reg, source_select_reg, match_irq_enable_reg,
                        divider_select_reg};

  // Read-only count.
  // The count index has no write decode at all, so a write there is dropped.
  always @* begin
    case (reg_addr)
      `PWC_IDX_SC:  rdata_next = status_word;
      `PWC_IDX_CNT: rdata_next = count_reg;
      `PWC_IDX_LIM: rdata_next = match_limit_reg;
      default:      rdata_next = `PWC_RD_UNMAPPED;
    endcase
  end

  // Internal ports only.
  // Read data is zero outside the answer cycle, so the processor bus may
  // combine several slaves with a plain OR without any select of its own.
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= `PWC_ZERO8;
    end else if (reg_read) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= `PWC_ZERO8;
    end
  end

endmodule // pwc_top

// ==== testbench/pwc_top_assertions.sv ====
/*
  Checker for the periodic wake-up counter: read port, flag and request.
  Assumes it is bound to pwc_top and sees only that module's ports.
*/
`timescale 1ns/10ps
`include "pwc_consts.vh"

module pwc_chk (
  // Clock and reset.
  input wire                   mclk,
  input wire                   reset_n,
  // Watched ports.
  input wire                   debug_active,
  input wire [`PWC_ADDR_W-1:0] reg_addr,
  input wire [7:0]             reg_wdata,
  input wire                   reg_write,
  input wire                   reg_read,
  input wire [7:0]             reg_rdata,
  input wire                   match_irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire sc_wr;
  assign sc_wr = reg_write && reg_addr == `PWC_IDX_SC;
  sequence frozen_read;
    debug_active && reg_read && reg_addr == `PWC_IDX_CNT;
  endsequence

  AST_RDATA_IDLE: assert property (!reg_read |=> reg_rdata == 8'h00)
    else $error("read data not zero outside an answer");
  AST_UNMAPPED: assert property (reg_read && reg_addr == 2'h3 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_IRQ_GATED: assert property (sc_wr && !reg_wdata[4] |=> !match_irq)
    else $error("request raised while disabled");
  AST_IRQ_STANDS: assert property (match_irq && !reg_write |=> match_irq)
    else $error("request dropped without a write");
  AST_CLEAR_FROZEN: assert property (sc_wr && reg_wdata[7] && debug_active |=> !match_irq)
    else $error("flag clear did not withdraw request");
  AST_FLAG_SHOWN: assert property (reg_read && reg_addr == `PWC_IDX_SC && match_irq
    |=> reg_rdata[7])
    else $error("flag not visible while request high");
  AST_NO_MATCH_FROZEN: assert property (debug_active && $past(debug_active) && !match_irq
    && !reg_write |=> !match_irq)
    else $error("match while frozen");
  AST_COUNT_FROZEN: assert property (frozen_read ##1 frozen_read |=> $stable(reg_rdata))
    else $error("count moved while frozen");
endmodule // pwc_chk

bind pwc_top pwc_chk u_chk (.mclk(mclk), .reset_n(reset_n), .debug_active(debug_active),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .match_irq(match_irq));

// ==== testbench/pwc_top_bench.sv ====
/*
  Self-checking bench for the periodic wake-up counter.
  Assumes source clocks are driven here far slower than mclk.
*/
`timescale 1ns/10ps
`include "pwc_consts.vh"

module pwc_top_bench;
  reg        mclk = 1'b0;
  reg        reset_n = 1'b0;
  reg  [2:0] src_clk = 3'h0;
  reg        deep_stop = 1'b0;
  reg        light_stop = 1'b0;
  reg        debug_active = 1'b0;
  reg  [1:0] reg_addr = 2'h0;
  reg  [7:0] reg_wdata = 8'h00;
  reg        reg_write = 1'b0;
  reg        reg_read = 1'b0;
  wire [7:0] reg_rdata;
  wire       match_irq;
  integer    failures = 0;
  integer    total_checks = 0;
  integer    cycles = 0;
  integer    i;
  reg [17:0] rows [0:4];
  reg [3:0]  codes [0:3];
  integer    ratios [0:3];

  pwc_top dut (.mclk(mclk), .reset_n(reset_n), .low_power_osc_clock(src_clk[0]),
    .external_ref_clock(src_clk[1]), .internal_ref_clock(src_clk[2]),
    .deep_stop_mode(deep_stop), .light_stop_mode(light_stop), .debug_active(debug_active),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .match_irq(match_irq));

  always #12.5 mclk = ~mclk;

  // Cuts a hang short well beyond the expected run length.
  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      test_done;
    end
  end

  task test_done;
    begin
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  task chk(input string name, input [7:0] seen, input [7:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("BAD %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask

  task wr(input [1:0] a, input [7:0] d);
    begin
      @(posedge mclk);
      reg_write <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_write <= 1'b0;
      #1;
    end
  endtask

  task rdc(input string name, input [1:0] a, input [7:0] exp);
    begin
      @(posedge mclk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_read <= 1'b0;
      #1;
      chk(name, reg_rdata, exp);
    end
  endtask

  task pulse(input integer which, input integer n);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1) begin
        @(posedge mclk);
        src_clk[which] <= 1'b1;
        repeat (4) @(posedge mclk);
        src_clk[which] <= 1'b0;
        repeat (4) @(posedge mclk);
      end
    end
  endtask

  initial begin
    rows = '{{2'h2, 8'h5a, 8'h5a}, {2'h1, 8'h77, 8'h00}, {2'h3, 8'hff, 8'h00},
             {2'h0, 8'h10, 8'h10}, {2'h2, 8'h00, 8'h00}};
    codes = '{4'h9, 4'ha, 4'hb, 4'h1};
    ratios = '{2, 4, 10, 8};
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    rdc("control", 2'h0, 8'h00);
    rdc("count", 2'h1, 8'h00);
    rdc("limit", 2'h2, 8'h00);
    for (i = 0; i < 5; i = i + 1) begin
      wr(rows[i][17:16], rows[i][15:8]);
      rdc("row", rows[i][17:16], rows[i][7:0]);
    end
    wr(2'h2, 8'h02);
    wr(2'h0, 8'h18);
    pulse(0, 2);
    rdc("count", 2'h1, 8'h02);
    chk("irq", {7'h00, match_irq}, 8'h00);
    pulse(0, 1);
    rdc("count", 2'h1, 8'h00);
    chk("irq", {7'h00, match_irq}, 8'h01);
    rdc("control", 2'h0, 8'h98);
    wr(2'h0, 8'h18);
    chk("irq", {7'h00, match_irq}, 8'h01);
    wr(2'h0, 8'h98);
    chk("irq", {7'h00, match_irq}, 8'h00);
    rdc("control", 2'h0, 8'h18);
    for (i = 0; i < 4; i = i + 1) begin
      wr(2'h0, {4'h0, codes[i]});
      rdc("count", 2'h1, 8'h00);
      pulse(0, ratios[i] - 1);
      rdc("count", 2'h1, 8'h00);
      pulse(0, 1);
      rdc("count", 2'h1, 8'h01);
    end
    wr(2'h2, 8'h02);
    rdc("count", 2'h1, 8'h00);
    wr(2'h0, 8'h48);
    pulse(2, 1);
    pulse(0, 1);
    pulse(1, 1);
    rdc("count", 2'h1, 8'h01);
    wr(2'h0, 8'h28);
    rdc("count", 2'h1, 8'h00);
    light_stop <= 1'b1;
    pulse(1, 999);
    rdc("count", 2'h1, 8'h00);
    pulse(1, 1);
    rdc("count", 2'h1, 8'h01);
    wr(2'h0, 8'h48);
    deep_stop <= 1'b1;
    pulse(2, 1);
    rdc("count", 2'h1, 8'h00);
    wr(2'h0, 8'h08);
    pulse(0, 1);
    rdc("count", 2'h1, 8'h01);
    deep_stop <= 1'b0;
    debug_active <= 1'b1;
    pulse(0, 2);
    @(posedge mclk);
    reg_read <= 1'b1;
    reg_addr <= 2'h1;
    repeat (2) @(posedge mclk);
    reg_read <= 1'b0;
    rdc("count", 2'h1, 8'h01);
    wr(2'h0, 8'h88);
    debug_active <= 1'b0;
    pulse(0, 1);
    rdc("count", 2'h1, 8'h02);
    wr(2'h0, 8'h00);
    pulse(0, 1);
    rdc("count", 2'h1, 8'h00);
    test_done;
  end
endmodule // pwc_top_bench
